// ===== logic/dpic_top.v
// dpic_top.v: input reference selection, feedback choice, loop state
// control and per-reference pre-dividers for the loop input side.
// Assumes inputs synchronous to clock_i, references already sampled,
// and an 8-bit register port with read data one cycle after the strobe.
//
// Contract
// RQ1: code 000 picks reference automatically
// RQ2: code 001 follows general-purpose pin level
// RQ3: codes 100/101 force reference 0/1
// RQ4: software avoids codes 010, 011, 110, 111
// RQ5: feedback codes 000-011 use internal divider
// RQ6: feedback 100/101 external from reference 0/1
// RQ7: revert bit picks revertive or non-revertive
// RQ8: phase bit 0 absorbs switch phase step
// RQ9: phase bit 1 slews toward new phase
// RQ10: priority bit picks primary input
// RQ11: exclude bit removes reference 1
// RQ12: exclude bit removes reference 0
// RQ13: state code 00 runs automatically
// RQ14: state code 01 forces free run
// RQ15: codes 10/11 force normal/holdover
// RQ16: reference 0 divided by 21-bit ratio
// RQ17: reference 1 divided by 21-bit ratio
// RQ18: reserved bits written zero, read undefined
// RQ19: auto uses valid primary, else other
//
// register map (byte port, 8-bit data)
//   0x08 select: [7:5] reference choice, [4:2] feedback
//        source choice, [1] revertive switch enable,
//        [0] switch phase behaviour
//   0x09 primary reference pick in [0]
//   0x0A [5] input1 exclude, [4] input0 exclude,
//        [1:0] loop state control
//   0x0B..0x0D input0 ratio, bits 20:16, 15:8, 7:0
//   0x0E..0x10 input1 ratio, same split
//   0x11 status: [5:4] qualified, [3] slewing,
//        [2] active reference, [1:0] loop state
//
// each ratio byte lands on its own, so the divider runs on
// a mixed ratio for a few cycles while software rewrites all
// three bytes; the divider compares against the live value,
// so a shrinking ratio wraps at once instead of counting out.
//
// reserved codes of the reference choice fall back to the
// automatic rule; that keeps the loop on a usable input
// instead of freezing on whatever was picked last.
//
// loop state codes on loop_state_o:
//   0 free oscillation, 1 normal tracking, 2 holdover;
//   code 3 is never produced.
//
// phase outputs: phase_absorb_o is a one-cycle request
// beside switch_pulse_o; phase_slew_o stands SLEW_CYC
// cycles after a switch when the phase bit is set.
// the slope limit itself lives in the loop filter, which
// sits outside this block.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "dpic_consts.vh"

module dpic_top #(
    parameter PRE_W = 21,
    parameter QUAL_CYC = (`DPIC_QUAL_NS + `DPIC_CLK_NS - 1) / `DPIC_CLK_NS,
    parameter SLEW_CYC = `DPIC_SLEW_NS / `DPIC_CLK_NS
) (
    // clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // register port
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // references and qualifiers
    input wire [1:0] ref_clk_i,
    input wire [1:0] ref_valid_i,
    input wire ref_pin_sel_i,
    // loop side
    output wire [1:0] ref_div_o,
    output reg active_ref_o,
    output reg ext_fb_en_o,
    output reg ext_fb_ref_o,
    output reg [1:0] loop_state_o,
    output reg switch_pulse_o,
    output reg phase_absorb_o,
    output reg phase_slew_o
);

    // loop states; the same codes go out on loop_state_o,
    // so a forced state and an automatic one look alike
    localparam [1:0] S_FREE = 2'h0;
    localparam [1:0] S_NORMAL = 2'h1;
    localparam [1:0] S_HOLD = 2'h2;

    // software registers
    reg [7:0] sel_q;
    reg pri_q;
    reg excl1_q;
    reg excl0_q;
    reg [1:0] stctl_q;
    reg [PRE_W-1:0] pre_q [0:1];

    wire [2:0] ref_code = sel_q[`DPIC_SEL_REF_HI:`DPIC_SEL_REF_LO];
    wire [2:0] fb_code = sel_q[`DPIC_SEL_FB_HI:`DPIC_SEL_FB_LO];
    wire revert = sel_q[`DPIC_SEL_REVERTIVE_SWITCH_ENABLE_BIT];
    wire phase_track = sel_q[`DPIC_SEL_PHASE_BIT];

    // register writes; reserved bits are dropped and read back as zero (see RQ18)
    // a write lands at the strobe edge, so outputs that
    // depend on it follow one cycle later; unmapped
    // offsets and the status byte ignore writes
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_q <= `DPIC_RST_SEL;
            pri_q <= 1'b0;
            excl1_q <= 1'b0;
            excl0_q <= 1'b0;
            stctl_q <= `DPIC_ST_AUTO;
            pre_q[0] <= `DPIC_RST_PRE;
            pre_q[1] <= `DPIC_RST_PRE;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `DPIC_OFF_SEL) begin
                sel_q <= reg_wdata_i;
            end else if (reg_addr_i == `DPIC_OFF_PRI) begin
                pri_q <= reg_wdata_i[0];
            end else if (reg_addr_i == `DPIC_OFF_EXCL) begin
                excl1_q <= reg_wdata_i[`DPIC_EXCL_IN1_BIT];
                excl0_q <= reg_wdata_i[`DPIC_EXCL_IN0_BIT];
                stctl_q <= reg_wdata_i[`DPIC_EXCL_ST_HI:`DPIC_EXCL_ST_LO];
            end else if (reg_addr_i == `DPIC_OFF_INPUT0_PREDIVIDE_RATIO_H) begin
                pre_q[0][20:16] <= reg_wdata_i[4:0];
            end else if (reg_addr_i == `DPIC_OFF_INPUT0_PREDIVIDE_RATIO_M) begin
                pre_q[0][15:8] <= reg_wdata_i;
            end else if (reg_addr_i == `DPIC_OFF_INPUT0_PREDIVIDE_RATIO_L) begin
                pre_q[0][7:0] <= reg_wdata_i;
            end else if (reg_addr_i == `DPIC_OFF_INPUT1_PREDIVIDE_RATIO_H) begin
                pre_q[1][20:16] <= reg_wdata_i[4:0];
            end else if (reg_addr_i == `DPIC_OFF_INPUT1_PREDIVIDE_RATIO_M) begin
                pre_q[1][15:8] <= reg_wdata_i;
            end else if (reg_addr_i == `DPIC_OFF_INPUT1_PREDIVIDE_RATIO_L) begin
                pre_q[1][7:0] <= reg_wdata_i;
            end
        end
    end

    // per-reference qualification: valid must hold QUAL_CYC cycles
    // a single dropout restarts the count; this debounce
    // stops the switchover logic chattering on a marginal
    // input. the counter is 8 bits, so QUAL_CYC above 255
    // would need a wider one.
    wire [1:0] qual_q;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ref
            reg [7:0] qcnt_q;
            reg qok_q;
            reg clk_prev_q;
            reg [PRE_W-1:0] dcnt_q;
            reg div_q;
            reg dout_q;
            wire [PRE_W-1:0] dcnt_inc = dcnt_q + {{(PRE_W-1){1'b0}}, 1'b1};
            // one flop per bit keeps each vector single-driven
            assign qual_q[gi] = qok_q;
            assign ref_div_o[gi] = dout_q;
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    qcnt_q <= 8'h00;
                    qok_q <= 1'b0;
                end else if (!ref_valid_i[gi]) begin
                    qcnt_q <= 8'h00;
                    qok_q <= 1'b0;
                end else if (qcnt_q == QUAL_CYC[7:0] - 8'h01) begin
                    qok_q <= 1'b1;
                end else begin
                    qcnt_q <= qcnt_q + 8'h01;
                end
            end
            // pre-divider: toggle output every ratio rising edges; ratio 0 acts as 1
            // the reference is sampled as a level, so it must
            // stay below half the clock rate or edges are lost
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    clk_prev_q <= 1'b0;
                    dcnt_q <= {PRE_W{1'b0}};
                    div_q <= 1'b0;
                end else begin
                    clk_prev_q <= ref_clk_i[gi];
                    if (ref_clk_i[gi] && !clk_prev_q) begin
                        if (dcnt_inc >= pre_q[gi]) begin // see RQ16 see RQ17
                            dcnt_q <= {PRE_W{1'b0}};
                            div_q <= ~div_q;
                        end else begin
                            dcnt_q <= dcnt_inc;
                        end
                    end
                end
            end
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    dout_q <= 1'b0;
                end else begin
                    dout_q <= div_q;
                end
            end
        end
    endgenerate

    // automatic choice; codes 010/011/110/111 fall back to auto (see RQ4)
    // non-revertive keeps the current input while it is
    // usable; revertive goes back to the primary as soon
    // as it qualifies again. with nothing usable the last
    // pick is held, so the loop can sit in holdover on it.
    reg ref_d;
    wire prim = pri_q; // see RQ10
    wire [1:0] usable = qual_q & ~{excl1_q, excl0_q}; // see RQ11 see RQ12
    always @* begin
        ref_d = active_ref_o;
        if (ref_code == `DPIC_REF_PIN) begin
            ref_d = ref_pin_sel_i; // see RQ2
        end else if (ref_code == `DPIC_REF_FORCE0) begin
            ref_d = 1'b0; // see RQ3
        end else if (ref_code == `DPIC_REF_FORCE1) begin
            ref_d = 1'b1; // see RQ3
        end else if (usable[active_ref_o] && !revert) begin
            ref_d = active_ref_o; // see RQ1 see RQ7
        end else if (usable[prim]) begin
            ref_d = prim; // see RQ19 see RQ7
        end else if (usable[~prim]) begin
            ref_d = ~prim; // see RQ19
        end
    end

    // loop state machine
    // forcing codes override the automatic walk at once;
    // on return to automatic the walk resumes from the
    // forced state. lock is judged only from usability of
    // the chosen input, phase lock detection is elsewhere.
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg any_lock_d;
    always @* begin
        st_d = st_q;
        any_lock_d = usable[ref_d];
        case (stctl_q)
            `DPIC_ST_FREE: st_d = S_FREE; // see RQ14
            `DPIC_ST_NORMAL: st_d = S_NORMAL; // see RQ15
            `DPIC_ST_HOLD: st_d = S_HOLD; // see RQ15
            default: begin // see RQ13
                case (st_q)
                    S_FREE: if (any_lock_d) st_d = S_NORMAL;
                    S_NORMAL: if (!any_lock_d) st_d = S_HOLD;
                    default: if (any_lock_d) st_d = S_NORMAL;
                endcase
            end
        endcase
    end

    // state, selection and phase handling on a switch
    // a new switch during a slew restarts the window, so
    // back-to-back switches extend it rather than stack
    reg [7:0] slew_q;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= S_FREE;
            active_ref_o <= 1'b0;
            loop_state_o <= S_FREE;
            switch_pulse_o <= 1'b0;
            phase_absorb_o <= 1'b0;
            phase_slew_o <= 1'b0;
            slew_q <= 8'h00;
            ext_fb_en_o <= 1'b0;
            ext_fb_ref_o <= 1'b0;
        end else begin
            st_q <= st_d;
            loop_state_o <= st_d;
            active_ref_o <= ref_d;
            switch_pulse_o <= (ref_d != active_ref_o);
            // absorb is a one-cycle request; slew stands for the slew window
            phase_absorb_o <= (ref_d != active_ref_o) && !phase_track; // see RQ8
            if ((ref_d != active_ref_o) && phase_track) begin // see RQ9
                slew_q <= SLEW_CYC[7:0];
                phase_slew_o <= 1'b1;
            end else if (slew_q > 8'h01) begin
                slew_q <= slew_q - 8'h01;
            end else begin
                slew_q <= 8'h00;
                phase_slew_o <= 1'b0;
            end
            ext_fb_en_o <= (fb_code == `DPIC_FB_EXT0) || (fb_code == `DPIC_FB_EXT1); // see RQ5 see RQ6
            ext_fb_ref_o <= (fb_code == `DPIC_FB_EXT1); // see RQ6
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    // the bus is zero between reads, so an or-combined read
    // mux outside this block needs no extra gating
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `DPIC_OFF_SEL) begin
                reg_rdata_o <= sel_q;
            end else if (reg_addr_i == `DPIC_OFF_PRI) begin
                reg_rdata_o <= {7'h00, pri_q};
            end else if (reg_addr_i == `DPIC_OFF_EXCL) begin
                reg_rdata_o <= {2'h0, excl1_q, excl0_q, 2'h0, stctl_q};
            end else if (reg_addr_i == `DPIC_OFF_INPUT0_PREDIVIDE_RATIO_H) begin
                reg_rdata_o <= {3'h0, pre_q[0][20:16]};
            end else if (reg_addr_i == `DPIC_OFF_INPUT0_PREDIVIDE_RATIO_M) begin
                reg_rdata_o <= pre_q[0][15:8];
            end else if (reg_addr_i == `DPIC_OFF_INPUT0_PREDIVIDE_RATIO_L) begin
                reg_rdata_o <= pre_q[0][7:0];
            end else if (reg_addr_i == `DPIC_OFF_INPUT1_PREDIVIDE_RATIO_H) begin
                reg_rdata_o <= {3'h0, pre_q[1][20:16]};
            end else if (reg_addr_i == `DPIC_OFF_INPUT1_PREDIVIDE_RATIO_M) begin
                reg_rdata_o <= pre_q[1][15:8];
            end else if (reg_addr_i == `DPIC_OFF_INPUT1_PREDIVIDE_RATIO_L) begin
                reg_rdata_o <= pre_q[1][7:0];
            end else if (reg_addr_i == `DPIC_OFF_STAT) begin
                reg_rdata_o <= {2'h0, qual_q, phase_slew_o, active_ref_o, st_q};
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule // dpic_top

// ===== shared/dpic_consts.vh
// dpic_consts.vh: offsets, field positions, reset values and timings in ns
// for the loop input reference control block; definitions only.
`ifndef DPIC_CONSTS_VH
`define DPIC_CONSTS_VH

// byte register offsets (8-bit register port)
`define DPIC_ADDR_W 8
`define DPIC_OFF_SEL 8'h08
`define DPIC_OFF_PRI 8'h09
`define DPIC_OFF_EXCL 8'h0A
`define DPIC_OFF_INPUT0_PREDIVIDE_RATIO_H 8'h0B
`define DPIC_OFF_INPUT0_PREDIVIDE_RATIO_M 8'h0C
`define DPIC_OFF_INPUT0_PREDIVIDE_RATIO_L 8'h0D
`define DPIC_OFF_INPUT1_PREDIVIDE_RATIO_H 8'h0E
`define DPIC_OFF_INPUT1_PREDIVIDE_RATIO_M 8'h0F
`define DPIC_OFF_INPUT1_PREDIVIDE_RATIO_L 8'h10
`define DPIC_OFF_STAT 8'h11

// field positions in the select register
`define DPIC_SEL_REF_HI 7
`define DPIC_SEL_REF_LO 5
`define DPIC_SEL_FB_HI 4
`define DPIC_SEL_FB_LO 2
`define DPIC_SEL_REVERTIVE_SWITCH_ENABLE_BIT 1
`define DPIC_SEL_PHASE_BIT 0
// field positions in the exclude/state register
`define DPIC_EXCL_IN1_BIT 5
`define DPIC_EXCL_IN0_BIT 4
`define DPIC_EXCL_ST_HI 1
`define DPIC_EXCL_ST_LO 0

// reset values
`define DPIC_RST_SEL 8'h03
`define DPIC_RST_PRI 8'h00
`define DPIC_RST_EXCL 8'h00
`define DPIC_RST_PRE 21'h000000

// reference choice codes
`define DPIC_REF_AUTO 3'h0
`define DPIC_REF_PIN 3'h1
`define DPIC_REF_FORCE0 3'h4
`define DPIC_REF_FORCE1 3'h5
// feedback codes
`define DPIC_FB_EXT0 3'h4
`define DPIC_FB_EXT1 3'h5
// state control codes
`define DPIC_ST_AUTO 2'h0
`define DPIC_ST_FREE 2'h1
`define DPIC_ST_NORMAL 2'h2
`define DPIC_ST_HOLD 2'h3

// timing: qualification time and phase slew window length
`define DPIC_QUAL_NS 800
`define DPIC_SLEW_NS 200
`define DPIC_CLK_NS 50

`endif

// ===== test/dpic_top_properties.sv
// dpic_top_properties.sv: port-level checks of the loop input control block
// assumes a single clock domain and writes taking effect in the next cycle
`timescale 1ns/1ps
`include "dpic_consts.vh"
module dpic_top_properties (
    // clock, reset and register port
    input wire clock_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    // loop side
    input wire active_ref_o,
    input wire ext_fb_en_o,
    input wire ext_fb_ref_o,
    input wire [1:0] loop_state_o,
    input wire switch_pulse_o,
    input wire phase_absorb_o,
    input wire phase_slew_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // register write at one offset
    sequence s_wr(a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    // switch that has to follow the new phase
    sequence s_track;
        switch_pulse_o && !phase_absorb_o;
    endsequence
    a_force_ref_pick: assert property (s_wr(`DPIC_OFF_SEL) ##0 reg_wdata_i[7:6] == 2'h2
        |-> ##2 active_ref_o == $past(reg_wdata_i[5], 2)) else $error("forced reference not used");
    a_ext_fb_pick: assert property (s_wr(`DPIC_OFF_SEL) ##0 reg_wdata_i[4:3] == 2'h2
        |-> ##2 ext_fb_en_o && ext_fb_ref_o == $past(reg_wdata_i[2], 2)) else $error("external feedback wrong");
    a_int_fb_used: assert property (s_wr(`DPIC_OFF_SEL) ##0 !reg_wdata_i[4]
        |-> ##2 !ext_fb_en_o) else $error("internal feedback not used");
    a_state_force_code: assert property (s_wr(`DPIC_OFF_EXCL) ##0 reg_wdata_i[1:0] != `DPIC_ST_AUTO
        |-> ##2 loop_state_o == $past(reg_wdata_i[1:0], 2) - 2'h1) else $error("forced state not taken");
    a_state_legal: assert property (loop_state_o != 2'h3) else $error("loop state out of range");
    a_absorb_with_switch: assert property (phase_absorb_o |-> switch_pulse_o) else $error("absorb without switch");
    a_track_slews: assert property (s_track |-> ##[0:1] phase_slew_o) else $error("no phase slew");
    a_read_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data not idle");
endmodule // dpic_top_properties

bind dpic_top dpic_top_properties i_dpic_top_properties (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .active_ref_o(active_ref_o), .ext_fb_en_o(ext_fb_en_o),
    .ext_fb_ref_o(ext_fb_ref_o), .loop_state_o(loop_state_o), .switch_pulse_o(switch_pulse_o),
    .phase_absorb_o(phase_absorb_o), .phase_slew_o(phase_slew_o));

// ===== test/tb_dpic_top.sv
// tb_dpic_top.sv: directed scenarios for the loop input control block
// assumes the bound checker and references that run at a quarter clock rate
`timescale 1ns/1ps
`include "dpic_consts.vh"
module tb_dpic_top;
    reg clock_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [1:0] rclk = 2'h0;
    reg [1:0] valid = 2'h3;
    reg pin = 1'b0;
    reg [1:0] ph = 2'h0;
    wire [7:0] rdata;
    wire [1:0] div;
    wire [1:0] state;
    wire act, fb_en, fb_ref, sw, absorb, slew;
    integer num_errors = 0;
    integer num_checks = 0;
    integer cyc = 0;
    integer i;

    dpic_top i_dpic_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ref_clk_i(rclk), .ref_valid_i(valid),
        .ref_pin_sel_i(pin), .ref_div_o(div), .active_ref_o(act), .ext_fb_en_o(fb_en),
        .ext_fb_ref_o(fb_ref), .loop_state_o(state), .switch_pulse_o(sw), .phase_absorb_o(absorb),
        .phase_slew_o(slew));

    initial begin
        forever #25 clock_i = ~clock_i;
    end
    // reference clocks with a four-cycle period; hang guard well above the run length
    always @(posedge clock_i) begin
        ph <= ph + 2'h1;
        rclk <= {2{ph[1]}};
        cyc = cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            finish_test;
        end
    end

    task finish_test;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input string name, input [7:0] e, input [7:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("wrong value %s expected %h seen %h", name, e, g);
            end
        end
    endtask
    // bus tasks start on a rising edge and end at a falling edge with outputs settled
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge clock_i);
            addr <= a; wdata <= d; wr <= 1'b1;
            @(posedge clock_i);
            wr <= 1'b0;
            @(posedge clock_i);
            @(negedge clock_i);
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] e);
        begin
            @(posedge clock_i);
            addr <= a; rd <= 1'b1;
            @(posedge clock_i);
            rd <= 1'b0;
            @(negedge clock_i);
            chk("read data", e, rdata);
        end
    endtask
    task set_in(input [1:0] v, input p);
        begin
            @(posedge clock_i);
            valid <= v; pin <= p;
        end
    endtask
    // waits bounded for {loop state, active reference}
    task wait_out(input [2:0] e);
        integer k;
        begin
            for (k = 0; k < 60 && {state, act} !== e; k = k + 1) @(negedge clock_i);
            chk("state and reference", {5'h0, e}, {5'h0, state, act});
        end
    endtask
    task div_per(input integer x, input [7:0] e);
        integer n;
        reg v;
        begin
            v = div[x];
            for (n = 0; n < 100 && div[x] === v; n = n + 1) @(negedge clock_i);
            v = div[x];
            for (n = 0; n < 100 && div[x] === v; n = n + 1) @(negedge clock_i);
            chk("divider half period", e, n[7:0]);
        end
    endtask
    function [7:0] tv(input [7:0] a);
        case (a)
            8'h08: tv = 8'h17; 8'h09: tv = 8'h01; 8'h0A: tv = 8'h33; 8'h0B: tv = 8'h1F;
            8'h0E: tv = 8'h15; default: tv = a ^ 8'hA5;
        endcase
    endfunction

    task t_reset;
        begin
            for (i = 8; i <= 16; i = i + 1) rd_chk(i[7:0], (i == 8) ? `DPIC_RST_SEL : 8'h00);
            div_per(0, 8'h04);
        end
    endtask
    task t_regs;
        begin
            for (i = 8; i <= 16; i = i + 1) wr_reg(i[7:0], tv(i[7:0]));
            wr_reg(8'h40, 8'h55);
            for (i = 8; i <= 16; i = i + 1) rd_chk(i[7:0], tv(i[7:0]));
            rd_chk(8'h40, 8'h00);
            wr_reg(`DPIC_OFF_EXCL, 8'h00);
            wr_reg(`DPIC_OFF_PRI, 8'h00);
        end
    endtask
    task t_force;
        begin
            wr_reg(`DPIC_OFF_SEL, 8'hA2); wait_out(3'b011);
            chk("switch pulse", 8'h01, {7'h00, sw});
            chk("phase absorb", 8'h01, {7'h00, absorb});
            wr_reg(`DPIC_OFF_SEL, 8'h80); wait_out(3'b010);
            wr_reg(`DPIC_OFF_SEL, 8'hA3); wait_out(3'b011);
            chk("phase slew", 8'h01, {7'h00, slew});
            chk("phase absorb", 8'h00, {7'h00, absorb});
            for (i = 0; i < 6; i = i + 1) begin
                wr_reg(`DPIC_OFF_SEL, {3'h4, i[2:0], 2'h3});
                chk("feedback enable", (i >= 4), fb_en);
                if (i >= 4) chk("feedback reference", (i == 5), fb_ref);
            end
            for (i = 1; i < 4; i = i + 1) begin
                wr_reg(`DPIC_OFF_EXCL, i[7:0]);
                chk("forced state", i - 1, state);
            end
            wr_reg(`DPIC_OFF_EXCL, 8'h00);
        end
    endtask
    task t_auto;
        begin
            wr_reg(`DPIC_OFF_SEL, 8'h03); wait_out(3'b010);
            wr_reg(`DPIC_OFF_PRI, 8'h01); wait_out(3'b011);
            wr_reg(`DPIC_OFF_EXCL, 8'h20); wait_out(3'b010);
            wr_reg(`DPIC_OFF_EXCL, 8'h10); wait_out(3'b011);
            wr_reg(`DPIC_OFF_EXCL, 8'h00);
            set_in(2'h1, 1'b0); wait_out(3'b010);
            set_in(2'h0, 1'b0); wait_out(3'b100);
            set_in(2'h3, 1'b0); wait_out(3'b011);
            wr_reg(`DPIC_OFF_SEL, 8'h01);
            wr_reg(`DPIC_OFF_PRI, 8'h00);
            repeat (30) @(negedge clock_i);
            wait_out(3'b011);
            wr_reg(`DPIC_OFF_SEL, 8'h03); wait_out(3'b010);
            wr_reg(`DPIC_OFF_SEL, 8'h23);
            set_in(2'h3, 1'b1); wait_out(3'b011);
            set_in(2'h3, 1'b0); wait_out(3'b010);
        end
    endtask
    task t_div;
        begin
            for (i = 11; i <= 16; i = i + 1) wr_reg(i[7:0], (i == 13) ? 8'h03 : ((i == 16) ? 8'h02 : 8'h00));
            div_per(0, 8'h0C);
            div_per(1, 8'h08);
        end
    endtask

    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_regs;
        t_force;
        t_auto;
        t_div;
        finish_test;
    end
endmodule // tb_dpic_top
